// ---- common/gp_timer_defines.vh ----
// Constants for the general purpose timer and main interrupt mask block.
// Assumes inclusion by bare name from the design file and the test bench.
`ifndef GP_TIMER_DEFINES_VH
`define GP_TIMER_DEFINES_VH

// Register indices (byte address is four times the index)
`define IDX_TIMER_CTRL      8'h11
`define IDX_TIMEOUT_HIGH    8'h12
`define IDX_TIMEOUT_LOW     8'h13
`define IDX_MAIN_MASK       8'h14
`define IDX_TIMER_MASK      8'h15
`define IDX_IRQ_STATUS      8'h20
`define IDX_CONTROL         8'h21
`define IDX_TIMER_STATE     8'h22

// Timer control fields
`define TRIG_MSB            7
`define TRIG_LSB            5
`define NORESP_EMV_BIT      1
`define NORESP_STEP_BIT     0
`define TIMER_CTRL_MASK     8'hE3

// Trigger codes
`define TRIG_CMD_ONLY       3'h0
`define TRIG_END_RX         3'h1
`define TRIG_START_RX       3'h2
`define TRIG_END_TX_NFC     3'h3

// Main mask bit positions
`define MASK_OSC            7
`define MASK_WATER_LEVEL    6
`define MASK_RX_START       5
`define MASK_RX_END         4
`define MASK_TX_END         3
`define MASK_COLLISION      2
`define MAIN_MASK_DEFINED   8'hFC

// Timer expiry mask bit in the timer mask register
`define MASK_GP_EXPIRE      5
`define TIMER_MASK_DEFINED  8'h20

// Status bit positions (main layout, bit 1 = timer expiry)
`define STAT_GP_EXPIRE      1
`define STATUS_DEFINED      8'hFE

// Control register bits (write one to act)
`define CTL_START_GP        0
`define CTL_SET_DEFAULT     1
`define CTL_FIELD_ON        2

// Carrier steps per timer count
`define GP_STEP_CARRIER     8
`define NR_STEP_SHORT       64
`define NR_STEP_LONG        4096

`define ZERO8               8'h00
`define ZERO16              16'h0000
`define ZERO32              32'h00000000
`endif

// ---- rtl/gp_timer_irq.v ----
// General purpose timer with trigger selection, no-response timer options and
// the main interrupt mask, reached over APB.
// Assumes carrier_tick is a one-cycle pulse per carrier period, and that the
// receive, transmit and oscillator events are one-cycle pulses on clk_sys.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "gp_timer_defines.vh"

// Behaviour
// - Trigger source from control bits seven..five
// - Code zero: start only by start command
// - Code one end of rx, two start rx
// - Code three: NFC end tx, whose expiry drops field
// - Sixteen-bit timeout, high 0x12, low 0x13
// - Low byte gives count bits seven..zero
// - Timer steps every eight carrier periods
// - Control bit zero picks no-response step
// - Control bit one selects EMV mode
// - Mask bit seven blocks oscillator event
// - Mask bit six blocks water level
// - Mask bits five, four block rx events
// - Mask bit three blocks tx end
// - Mask bit two blocks collision; 1,0 unused
// - Defaults cleared at reset and set-default
// - Timer expiry is own maskable source
module gp_timer_irq #(
    parameter CARRIER_DIV_W = 3
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        carrier_tick,
    input  wire        ev_osc_stable,
    input  wire        ev_water_level,
    input  wire        ev_rx_start,
    input  wire        ev_rx_end,
    input  wire        ev_tx_end,
    input  wire        ev_collision,
    input  wire        nfc_mode,
    output reg         irq,
    output reg         rf_field_on,
    output reg         gp_running,
    output reg         noresp_step_long,
    output reg         noresp_emv
);

    // =====================================================================
    // Registers
    // =====================================================================
    reg [7:0]               timer_trigger_and_noresp_control;
    reg [7:0]               gp_timeout_high_byte;
    reg [7:0]               gp_timeout_low_byte;
    reg [7:0]               main_irq_mask;
    reg [7:0]               timer_irq_mask;
    reg [7:0]               irq_status;
    reg [15:0]              gp_count;
    reg [CARRIER_DIV_W-1:0] carrier_div;
    reg                     field_drop_armed;

    localparam integer             DIV_LAST_I = `GP_STEP_CARRIER - 1;
    localparam [CARRIER_DIV_W-1:0] DIV_LAST   = DIV_LAST_I[CARRIER_DIV_W-1:0];

    wire       setup    = psel & ~penable;
    wire       access   = psel & penable;
    wire [9:0] word_idx = paddr[11:2];
    wire       wr_en    = access & pwrite & pstrb[0];
    wire [2:0] trig_sel = timer_trigger_and_noresp_control[`TRIG_MSB:`TRIG_LSB];

    function is_idx;
        input [9:0] idx;
        input [7:0] reg_idx;
        begin
            is_idx = (idx == {2'b00, reg_idx});
        end
    endfunction

    function mapped;
        input [9:0] idx;
        begin
            mapped = is_idx(idx, `IDX_TIMER_CTRL) | is_idx(idx, `IDX_TIMEOUT_HIGH) |
                     is_idx(idx, `IDX_TIMEOUT_LOW) | is_idx(idx, `IDX_MAIN_MASK) |
                     is_idx(idx, `IDX_TIMER_MASK) | is_idx(idx, `IDX_IRQ_STATUS) |
                     is_idx(idx, `IDX_CONTROL) | is_idx(idx, `IDX_TIMER_STATE);
        end
    endfunction

    wire ctl_wr      = wr_en & is_idx(word_idx, `IDX_CONTROL);
    wire set_default = ctl_wr & pwdata[`CTL_SET_DEFAULT];
    wire cmd_start   = ctl_wr & pwdata[`CTL_START_GP];

    // =====================================================================
    // Trigger selection
    // =====================================================================
    reg auto_trig;
    always @* begin
        case (trig_sel)
            `TRIG_CMD_ONLY:   auto_trig = 1'b0;
            `TRIG_END_RX:     auto_trig = ev_rx_end;
            `TRIG_START_RX:   auto_trig = ev_rx_start;
            `TRIG_END_TX_NFC: auto_trig = ev_tx_end & nfc_mode;
            default:          auto_trig = 1'b0;
        endcase
    end

    wire start_gp  = cmd_start | auto_trig;
    wire step_tick = carrier_tick & (carrier_div == DIV_LAST);
    wire gp_expire = gp_running & step_tick & (gp_count <= 16'h0001);

    // =====================================================================
    // General purpose timer
    // =====================================================================
    // A start while running reloads; a zero timeout expires on the first step.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gp_count         <= `ZERO16;
            carrier_div      <= {CARRIER_DIV_W{1'b0}};
            gp_running       <= 1'b0;
            field_drop_armed <= 1'b0;
            rf_field_on      <= 1'b0;
        end else begin
            if (start_gp) begin
                gp_count    <= {gp_timeout_high_byte, gp_timeout_low_byte};
                carrier_div <= {CARRIER_DIV_W{1'b0}};
                gp_running  <= 1'b1;
                field_drop_armed <= (trig_sel == `TRIG_END_TX_NFC) & ~cmd_start;
            end else if (gp_running) begin
                if (carrier_tick)
                    carrier_div <= (carrier_div == DIV_LAST) ? {CARRIER_DIV_W{1'b0}}
                                                              : carrier_div + 1'b1;
                if (gp_expire) begin
                    gp_running       <= 1'b0;
                    gp_count         <= `ZERO16;
                    field_drop_armed <= 1'b0;
                end else if (step_tick) begin
                    gp_count <= gp_count - 16'h0001;
                end
            end
            if (ctl_wr && pwdata[`CTL_FIELD_ON])
                rf_field_on <= 1'b1;
            else if (gp_expire && field_drop_armed)
                rf_field_on <= 1'b0;
            if (set_default) begin
                gp_running       <= 1'b0;
                field_drop_armed <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Configuration and interrupt registers
    // =====================================================================
    wire [7:0] events;
    assign events = {ev_osc_stable, ev_water_level, ev_rx_start, ev_rx_end,
                     ev_tx_end, ev_collision, gp_expire, 1'b0};
    wire [7:0] eff_mask;
    assign eff_mask = {main_irq_mask[`MASK_OSC],
                       main_irq_mask[`MASK_WATER_LEVEL],
                       main_irq_mask[`MASK_RX_START],
                       main_irq_mask[`MASK_RX_END],
                       main_irq_mask[`MASK_TX_END],
                       main_irq_mask[`MASK_COLLISION],
                       timer_irq_mask[`MASK_GP_EXPIRE],
                       1'b1};
    wire [7:0] status_clr = (wr_en & is_idx(word_idx, `IDX_IRQ_STATUS)) ? pwdata[7:0] : `ZERO8;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_trigger_and_noresp_control <= `ZERO8;
            gp_timeout_high_byte             <= `ZERO8;
            gp_timeout_low_byte              <= `ZERO8;
            main_irq_mask                    <= `ZERO8;
            timer_irq_mask                   <= `ZERO8;
            irq_status                       <= `ZERO8;
            irq                              <= 1'b0;
            noresp_step_long                 <= 1'b0;
            noresp_emv                       <= 1'b0;
        end else begin
            if (set_default) begin
                timer_trigger_and_noresp_control <= `ZERO8;
                gp_timeout_high_byte             <= `ZERO8;
                gp_timeout_low_byte              <= `ZERO8;
                main_irq_mask                    <= `ZERO8;
                timer_irq_mask                   <= `ZERO8;
            end else if (wr_en) begin
                if (is_idx(word_idx, `IDX_TIMER_CTRL))
                    timer_trigger_and_noresp_control <= pwdata[7:0] & `TIMER_CTRL_MASK;
                if (is_idx(word_idx, `IDX_TIMEOUT_HIGH))
                    gp_timeout_high_byte <= pwdata[7:0];
                if (is_idx(word_idx, `IDX_TIMEOUT_LOW))
                    gp_timeout_low_byte <= pwdata[7:0];
                if (is_idx(word_idx, `IDX_MAIN_MASK))
                    main_irq_mask <= pwdata[7:0] & `MAIN_MASK_DEFINED;
                if (is_idx(word_idx, `IDX_TIMER_MASK))
                    timer_irq_mask <= pwdata[7:0] & `TIMER_MASK_DEFINED;
            end
            // Set wins over a simultaneous write-one clear
            irq_status <= ((irq_status & ~status_clr) | events) & `STATUS_DEFINED;
            irq        <= |(irq_status & ~eff_mask);
            noresp_step_long <= timer_trigger_and_noresp_control[`NORESP_STEP_BIT];
            noresp_emv       <= timer_trigger_and_noresp_control[`NORESP_EMV_BIT];
        end
    end

    // =====================================================================
    // APB answer: no wait state, read data registered in the setup cycle
    // =====================================================================
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = `ZERO32;
        if (is_idx(word_idx, `IDX_TIMER_CTRL))
            next_prdata[7:0] = timer_trigger_and_noresp_control;
        else if (is_idx(word_idx, `IDX_TIMEOUT_HIGH))
            next_prdata[7:0] = gp_timeout_high_byte;
        else if (is_idx(word_idx, `IDX_TIMEOUT_LOW))
            next_prdata[7:0] = gp_timeout_low_byte;
        else if (is_idx(word_idx, `IDX_MAIN_MASK))
            next_prdata[7:0] = main_irq_mask;
        else if (is_idx(word_idx, `IDX_TIMER_MASK))
            next_prdata[7:0] = timer_irq_mask;
        else if (is_idx(word_idx, `IDX_IRQ_STATUS))
            next_prdata[7:0] = irq_status;
        else if (is_idx(word_idx, `IDX_CONTROL))
            next_prdata[7:0] = {5'h00, rf_field_on, 2'h0};
        else if (is_idx(word_idx, `IDX_TIMER_STATE))
            next_prdata = {gp_running, 15'h0000, gp_count};
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= `ZERO32;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped(word_idx);
            // An error answer always carries zero data, for writes as well
            if (setup && (!pwrite || !mapped(word_idx)))
                prdata <= next_prdata;
        end
    end

endmodule

// ---- verification/gp_timer_irq_props.sv ----
// Checker for the timer block, bound to the top module ports.
// Assumes one clock domain, clk_sys, with async active-low rst_n.
`timescale 1ns/1ps
module gp_timer_irq_props (
    input wire        clk_sys,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        ev_rx_start,
    input wire        ev_rx_end,
    input wire        ev_tx_end,
    input wire        irq,
    input wire        rf_field_on,
    input wire        gp_running,
    input wire        noresp_step_long,
    input wire        noresp_emv
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ========================================
    // Sequences
    sequence setup_ph;
        psel && !penable;
    endsequence
    sequence ctrl_wr;
        psel && penable && pwrite && pstrb[0] && paddr[11:2] == 10'h011;
    endsequence
    // ========================================
    // Properties
    answer_after_setup_a: assert property (setup_ph |=> pready)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    error_reads_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error answer");
    step_select_a: assert property (ctrl_wr |-> ##2 noresp_step_long == $past(pwdata[0], 2))
        else $error("step select wrong");
    emv_select_a: assert property (ctrl_wr |-> ##2 noresp_emv == $past(pwdata[1], 2))
        else $error("emv select wrong");
    reset_clear_a: assert property ($rose(rst_n) |-> !irq && !gp_running && !rf_field_on)
        else $error("outputs not clear after reset");
    start_cause_a: assert property ($rose(gp_running) |->
        $past(psel && penable && pwrite) || $past(ev_rx_end || ev_rx_start || ev_tx_end))
        else $error("timer started without cause");
    field_drop_a: assert property ($fell(rf_field_on) |-> $past(gp_running) || $past(gp_running, 2))
        else $error("field dropped without expiry");
endmodule

bind gp_timer_irq gp_timer_irq_props chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev_rx_start(ev_rx_start), .ev_rx_end(ev_rx_end),
    .ev_tx_end(ev_tx_end), .irq(irq), .rf_field_on(rf_field_on), .gp_running(gp_running),
    .noresp_step_long(noresp_step_long), .noresp_emv(noresp_emv)
);

// ---- verification/carrier_src.sv ----
// Carrier tick source standing in for the RF front end.
// Assumes DIV of at least two clock cycles per carrier period.
`timescale 1ns/1ps
module carrier_src #(
    parameter DIV = 4
) (
    input  wire clk_sys,
    input  wire rst_n,
    output reg  carrier_tick
);
    integer n;
    // One-cycle pulse per carrier period
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n <= 0;
            carrier_tick <= 1'b0;
        end else begin
            n <= (n == DIV - 1) ? 0 : n + 1;
            carrier_tick <= (n == DIV - 1);
        end
    end
endmodule

// ---- verification/gp_timer_irq_test.sv ----
// Self-checking bench for the timer and interrupt mask block.
// Assumes the carrier model and the checker are compiled with it.
`timescale 1ns/1ps
`include "gp_timer_defines.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module gp_timer_irq_test;
    localparam DIV = 4;
    reg         clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    reg         pwrite = 1'b0, nfc_mode = 1'b1, er;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0, seed = 32'd36, rd;
    reg  [7:0]  ev = 8'h00, m, v;
    wire [31:0] prdata;
    wire        pready, pslverr, carrier_tick, irq, rf_field_on, gp_running, nr_long, nr_emv;
    integer     n_mismatch = 0, total_checks = 0, i, j, k, n;

    carrier_src #(.DIV(DIV)) far (.clk_sys(clk_sys), .rst_n(rst_n), .carrier_tick(carrier_tick));
    gp_timer_irq dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .carrier_tick(carrier_tick),
        .ev_osc_stable(ev[7]), .ev_water_level(ev[6]), .ev_rx_start(ev[5]), .ev_rx_end(ev[4]),
        .ev_tx_end(ev[3]), .ev_collision(ev[2]), .nfc_mode(nfc_mode), .irq(irq),
        .rf_field_on(rf_field_on), .gp_running(gp_running), .noresp_step_long(nr_long),
        .noresp_emv(nr_emv));

    initial forever #4 clk_sys = ~clk_sys;
    // ========================================
    // Helpers
    function automatic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Event index 0 end rx, 1 start rx, 2 end tx
    function automatic exp_trig(input integer code, input integer e, input nfc);
        return (code == 1 && e == 0) || (code == 2 && e == 1) || (code == 3 && e == 2 && nfc);
    endfunction
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input w, input [7:0] idx, input [7:0] d);
        integer t;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) begin n_mismatch++; conclude(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse(input integer b);
        @(posedge clk_sys);
        ev[b] <= 1'b1;
        @(posedge clk_sys);
        ev <= 8'h00;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task wait_idle(output integer c);
        c = 0;
        while (gp_running === 1'b1 && c < 20000) begin
            @(posedge clk_sys);
            c++;
        end
        if (c >= 20000) begin n_mismatch++; conclude(); end
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    // ========================================
    // Scenarios
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(0, 8'h11 + i, 8'h00);
            `CHK(rd[7:0], 8'h00)
        end
        for (i = 0; i < 16; i++) begin
            v = rnd();
            k = i % 4;
            m = (k == 0) ? `TIMER_CTRL_MASK : (k == 3) ? `MAIN_MASK_DEFINED : 8'hFF;
            apb(1, 8'h11 + k, v);
            apb(0, 8'h11 + k, 8'h00);
            `CHK(rd[7:0], v & m)
            if (k == 0) `CHK({nr_emv, nr_long}, v[1:0])
        end
        apb(0, 8'h30, 8'h00);
        `CHK(er, 1'b1)
        $display("test registers done");
        for (i = 0; i < 24; i++) begin
            apb(1, `IDX_CONTROL, 8'h02);
            apb(1, `IDX_TIMEOUT_HIGH, 8'h01);
            apb(1, `IDX_TIMER_CTRL, (i / 3) << 5);
            nfc_mode <= rnd();
            pulse(i % 3 == 0 ? 4 : i % 3 == 1 ? 5 : 3);
            `CHK(gp_running, exp_trig(i / 3, i % 3, nfc_mode))
        end
        $display("test triggers done");
        for (j = 0; j < 2; j++) begin
            v = rnd() % 4 + 1;
            n = j * 256 + v;
            apb(1, `IDX_CONTROL, 8'h02);
            apb(1, `IDX_IRQ_STATUS, 8'hFE);
            apb(1, `IDX_TIMEOUT_HIGH, j);
            apb(1, `IDX_TIMEOUT_LOW, v);
            apb(1, `IDX_CONTROL, 8'h01);
            repeat (2) @(posedge clk_sys);
            wait_idle(k);
            // Free-running carrier tick may shorten the first step
            `CHK(k + 2 > (n - 1) * 8 * DIV && k + 2 <= n * 8 * DIV + 8, 1'b1)
            `CHK(irq, 1'b1)
            apb(1, `IDX_TIMER_MASK, 8'h20);
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK(irq, 1'b0)
        end
        apb(1, `IDX_CONTROL, 8'h02);
        apb(1, `IDX_CONTROL, 8'h04);
        apb(1, `IDX_TIMER_CTRL, 8'h60);
        apb(1, `IDX_TIMEOUT_LOW, 8'h02);
        nfc_mode <= 1'b1;
        pulse(3);
        `CHK(rf_field_on, 1'b1)
        wait_idle(k);
        `CHK(rf_field_on, 1'b0)
        $display("test timer done");
        apb(1, `IDX_CONTROL, 8'h02);
        for (i = 0; i < 12; i++) begin
            k = 7 - i % 6;
            m = rnd();
            m[k] = (i < 6);
            apb(1, `IDX_MAIN_MASK, m);
            apb(1, `IDX_IRQ_STATUS, 8'hFE);
            pulse(k);
            `CHK(irq, ~m[k])
            apb(1, `IDX_IRQ_STATUS, 8'hFE);
            pulse(0);
            `CHK(irq, 1'b0)
        end
        apb(1, `IDX_CONTROL, 8'h02);
        apb(0, `IDX_MAIN_MASK, 8'h00);
        `CHK(rd[7:0], 8'h00)
        $display("test masks done");
        conclude();
    end
endmodule
